// *** dv/sxp_load_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// External load: integrates pin high time and times the pulses
// ------------------------------------------------------------
module sxp_load_model (
  input wire logic i_clk, // System clock
  input wire logic i_nrst, // Reset, active low
  input wire logic [5:0] i_pwm, // Pins from the timer
  output logic [5:0][31:0] o_falls, // Falling edges seen per pin
  output logic [5:0][31:0] o_high, // Length of the last high pulse
  output logic [5:0][31:0] o_period, // Fall to fall interval
  output logic [5:0][31:0] o_acc // Integrated high time, like an RC average
);
  logic [5:0] prev;
  logic [5:0][31:0] run_h;
  logic [5:0][31:0] run_p;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev <= '0;
      run_h <= '0;
      run_p <= '0;
      o_falls <= '0;
      o_high <= '0;
      o_period <= '0;
      o_acc <= '0;
    end else begin
      prev <= i_pwm;
      for (int c = 0; c < 6; c++) begin
        o_acc[c] <= o_acc[c] + 32'(i_pwm[c]);
        if (prev[c] && !i_pwm[c]) begin
          o_falls[c] <= o_falls[c] + 32'h0000_0001;
          o_high[c] <= run_h[c];
          o_period[c] <= run_p[c];
          run_h[c] <= '0;
          run_p[c] <= 32'h0000_0001;
        end else begin
          run_h[c] <= run_h[c] + 32'(i_pwm[c]);
          run_p[c] <= run_p[c] + 32'h0000_0001;
        end
      end
    end
  end
endmodule

// *** dv/test_sxp_pwm_top.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module test_sxp_pwm_top;
  localparam logic [1:0] OK = sxp_pkg::RESP_OKAY;
  localparam logic [31:0] PRE0 = sxp_pkg::OFF_PRE0;
  localparam logic [31:0] DTY0 = sxp_pkg::OFF_DUTY0;
  logic I_CLK = 1'b0;
  logic I_NRST = 1'b0;
  sxp_pkg::sxp_axi_req_type axi_req = '0;
  sxp_pkg::sxp_axi_rsp_type axi_rsp;
  logic [5:0] pwm;
  logic [5:0][31:0] falls;
  logic [5:0][31:0] high;
  logic [5:0][31:0] period;
  logic [5:0][31:0] acc;
  logic [31:0] hi;
  logic [31:0] per;
  logic [31:0] a0;
  int n_fail = 0;
  int comparisons = 0;

  always #12.5 I_CLK = ~I_CLK;

  sxp_pwm_top DUT (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_AXI(axi_req), .O_AXI(axi_rsp),
    .O_PWM(pwm));
  sxp_load_model LOAD (.i_clk(I_CLK), .i_nrst(I_NRST), .i_pwm(pwm), .o_falls(falls),
    .o_high(high), .o_period(period), .o_acc(acc));

  // ------------------------------------------------------------
  // Bus and measurement tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] ex);
    int t;
    t = 0;
    @(posedge I_CLK);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge I_CLK);
      t++;
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!(axi_req.bready && axi_rsp.bvalid) && t < 100);
    axi_req.bready <= 1'b0;
    `CHK("bresp", ex, axi_rsp.bresp)
    `CHK("write wait", 1'b1, t < 100)
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ex, input logic [1:0] exr);
    int t;
    t = 0;
    @(posedge I_CLK);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge I_CLK);
      t++;
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!(axi_req.rready && axi_rsp.rvalid) && t < 100);
    axi_req.rready <= 1'b0;
    `CHK("rdata", ex, axi_rsp.rdata)
    `CHK("rresp", exr, axi_rsp.rresp)
    `CHK("read wait", 1'b1, t < 100)
  endtask

  // Earlier falls may belong to the old setting, so callers skip them
  task automatic measure(input int ch, input int n);
    logic [31:0] f0;
    int t;
    f0 = falls[ch];
    t = 0;
    while (falls[ch] - f0 < n && t < 80000) begin
      @(posedge I_CLK);
      t++;
    end
    hi = high[ch];
    per = period[ch];
    `CHK("fall wait", 1'b1, t < 80000)
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge I_CLK);
    I_NRST <= 1'b1;
    repeat (2) @(posedge I_CLK);
    for (int i = 0; i < 12; i++) begin
      rd(PRE0 + 32'(i) * 4, 32'h0, OK);
      wr(PRE0 + 32'(i) * 4, 32'h1234_56C0 + 32'(i), OK);
      rd(PRE0 + 32'(i) * 4, 32'h0000_00C0 + 32'(i), OK);
      wr(PRE0 + 32'(i) * 4, 32'h0, OK);
    end
    rd(32'h0000_0040, 32'h0, sxp_pkg::RESP_SLVERR);
    wr(32'h0000_0040, 32'h0000_00FF, sxp_pkg::RESP_SLVERR);

    wr(DTY0, 32'h0000_0040, OK);
    for (int s = 0; s < 4; s++) begin
      wr(sxp_pkg::OFF_CLKSEL, 32'(s), OK);
      measure(0, (s == 0) ? 3 : 2);
      `CHK("cycle 8-bit", 32'h0000_00FF << s, per)
      `CHK("high 8-bit", 32'h0000_0040 << s, hi)
    end
    wr(sxp_pkg::OFF_CLKSEL, 32'h0, OK);
    wr(PRE0, 32'h0000_0002, OK);
    measure(0, 2);
    `CHK("cycle prescaled", 32'h0000_02FD, per)
    `CHK("high prescaled", 32'h0000_00C0, hi)

    wr(PRE0, 32'h0, OK);
    wr(DTY0, 32'h0000_00FF, OK);
    repeat (1100) @(posedge I_CLK);
    a0 = acc[0];
    repeat (255) @(posedge I_CLK);
    `CHK("full duty high time", 32'h0000_00FF, acc[0] - a0)
    wr(sxp_pkg::OFF_MODE, 32'h0000_0040, OK);
    wr(PRE0 + 32'h0000_0004, 32'h0000_0005, OK);
    wr(DTY0, 32'h0000_0010, OK);
    wr(DTY0 + 32'h0000_0004, 32'h0000_00F2, OK);
    measure(0, 3);
    `CHK("cycle 12-bit", 32'h0000_0FFF, per)
    `CHK("high 12-bit", 32'h0000_0210, hi)

    wr(sxp_pkg::OFF_MODE, 32'h0000_0044, OK);
    wr(DTY0 + 32'h0000_0008, 32'h0000_0081, OK);
    measure(2, 3);
    `CHK("basic pulse cycle", 32'h0000_0010, per)
    a0 = acc[2];
    repeat (256) @(posedge I_CLK);
    `CHK("division high time", 32'h0000_0081, acc[2] - a0)

    wr(sxp_pkg::OFF_PHASE, 32'h0000_0008, OK);
    repeat (4) @(posedge I_CLK);
    `CHK("pin 3 inverted", 1'b1, pwm[3])
    `CHK("pin 4 direct", 1'b0, pwm[4])

    wr(sxp_pkg::OFF_MODE, 32'h0000_0840, OK);
    wr(PRE0 + 32'h0000_0014, 32'h0000_0003, OK);
    wr(DTY0 + 32'h0000_0010, 32'h0000_0002, OK);
    wr(DTY0 + 32'h0000_0014, 32'h0000_0001, OK);
    measure(4, 1);
    `CHK("high 16-bit", 32'h0000_0102, hi)
    final_report();
  end

  initial begin
    repeat (100000) @(posedge I_CLK);
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end
endmodule

// *** rtl/sxp_pkg.sv ***
package sxp_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NCH = 6;
  localparam int NPAIR = 3;
  localparam int MODE_BITS = 12;
  // Pair p: 12-bit select at bit W12_BIT+2p, 16-bit select at W16_BIT+2p
  localparam int MODE_W12_BIT = 6;
  localparam int MODE_W16_BIT = 7;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [31:0] OFF_PRE0 = 32'h0000_0000;
  localparam logic [31:0] OFF_DUTY0 = 32'h0000_0018;
  localparam logic [31:0] OFF_MODE = 32'h0000_0030;
  localparam logic [31:0] OFF_PHASE = 32'h0000_0034;
  localparam logic [31:0] OFF_CLKSEL = 32'h0000_0038;
  localparam logic [31:0] OFF_STATUS = 32'h0000_003C;
  localparam logic [31:0] REG_STRIDE = 32'h0000_0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Duty counter end values (count runs 0 .. top)
  // ------------------------------------------------------------
  localparam logic [15:0] CNT_TOP8 = 16'h00FE;
  localparam logic [15:0] CNT_TOPDIV = 16'h00FF;
  localparam logic [15:0] CNT_TOP12 = 16'h0FFE;
  localparam logic [15:0] CNT_TOP16 = 16'hFFFE;
  localparam logic [7:0] DUTY_FULL8 = 8'hFF;
  localparam logic [3:0] SLOT_LAST = 4'hF;

  typedef enum logic [1:0] {SXP_W8, SXP_W12, SXP_W16, SXP_WBAD} sxp_width_type;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } sxp_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sxp_axi_rsp_type;

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic have_aw;
    logic have_w;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NCH-1:0][7:0] prescale;
    logic [NCH-1:0][7:0] duty;
    logic [MODE_BITS-1:0] mode_ctl;
    logic [NCH-1:0] phase_ctl;
    logic [1:0] clk_sel;
    logic [2:0] div_cnt;
    logic [NCH-1:0][7:0] pre_lat;
    logic [NCH-1:0][7:0] cg_cnt;
    logic [NCH-1:0][15:0] duty_cnt;
    logic [NCH-1:0][15:0] duty_lat;
    logic [NPAIR-1:0][15:0] shadow;
    logic [NCH-1:0] pins;
  } sxp_state_type;

endpackage

// *** rtl/sxp_pwm_top.sv ***
`timescale 1ns/100ps
module sxp_pwm_top (
  input wire logic I_CLK, // System clock, 40 MHz
  input wire logic I_NRST, // Asynchronous reset, active low
  input sxp_pkg::sxp_axi_req_type I_AXI, // AXI4-Lite master to slave
  output sxp_pkg::sxp_axi_rsp_type O_AXI, // AXI4-Lite slave to master
  output logic [5:0] O_PWM // PWM pins, one per channel
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  sxp_pkg::sxp_state_type state_reg;
  sxp_pkg::sxp_state_type state_next;
  logic tick;
  logic [sxp_pkg::NCH-1:0] pclk;
  logic [sxp_pkg::NCH-1:0] ovf;
  logic [sxp_pkg::NCH-1:0] raw;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic sxp_pkg::sxp_width_type width_of(
      input logic [sxp_pkg::MODE_BITS-1:0] m, input int p);
    logic [1:0] sel;
    sel = {m[sxp_pkg::MODE_W16_BIT + 2 * p], m[sxp_pkg::MODE_W12_BIT + 2 * p]};
    unique case (sel)
      2'h0: width_of = sxp_pkg::SXP_W8;
      2'h1: width_of = sxp_pkg::SXP_W12;
      2'h2: width_of = sxp_pkg::SXP_W16;
      2'h3: width_of = sxp_pkg::SXP_WBAD;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input sxp_pkg::sxp_width_type w,
                                         input logic dv);
    if (w == sxp_pkg::SXP_W12) begin
      top_of = sxp_pkg::CNT_TOP12;
    end else if (w == sxp_pkg::SXP_W16) begin
      top_of = sxp_pkg::CNT_TOP16;
    end else if (dv) begin
      top_of = sxp_pkg::CNT_TOPDIV;
    end else begin
      top_of = sxp_pkg::CNT_TOP8;
    end
  endfunction

  // Added pulses spread evenly: basic pulse k gets one when count > bitrev(~k)
  function automatic logic add_pulse(input logic [3:0] cnt4, input logic [3:0] k);
    logic [3:0] r;
    r = {~k[0], ~k[1], ~k[2], ~k[3]};
    add_pulse = cnt4 > r;
  endfunction

  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= sxp_pkg::OFF_STATUS);
  endfunction

  function automatic logic [31:0] rd_data(input sxp_pkg::sxp_state_type st,
                                          input logic [31:0] a);
    rd_data = 32'h0000_0000;
    for (int c = 0; c < sxp_pkg::NCH; c++) begin
      if (a == sxp_pkg::OFF_PRE0 + sxp_pkg::REG_STRIDE * 32'(c)) begin
        rd_data[7:0] = st.prescale[c];
      end
      if (a == sxp_pkg::OFF_DUTY0 + sxp_pkg::REG_STRIDE * 32'(c)) begin
        rd_data[7:0] = st.duty[c];
      end
    end
    if (a == sxp_pkg::OFF_MODE) begin
      rd_data[sxp_pkg::MODE_BITS-1:0] = st.mode_ctl;
    end
    if (a == sxp_pkg::OFF_PHASE) begin
      rd_data[sxp_pkg::NCH-1:0] = st.phase_ctl;
    end
    if (a == sxp_pkg::OFF_CLKSEL) begin
      rd_data[1:0] = st.clk_sel;
    end
    if (a == sxp_pkg::OFF_STATUS) begin
      rd_data[sxp_pkg::NCH-1:0] = st.pins;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8 * b +: 8] = strb[b] ? nw[8 * b +: 8] : old[8 * b +: 8];
    end
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    sxp_pkg::sxp_width_type w;
    logic [2:0] mask;
    logic [15:0] top;
    logic [15:0] wide;
    logic [31:0] wd;
    logic idle;
    logic dv;
    w = sxp_pkg::SXP_W8;
    mask = 3'h0;
    top = 16'h0000;
    wide = 16'h0000;
    wd = 32'h0000_0000;
    idle = 1'b0;
    dv = 1'b0;
    state_next = state_reg;
    pclk = '0;
    ovf = '0;
    raw = '0;

    // Bus: write response
    if (state_reg.bvalid && I_AXI.bready) begin
      state_next.bvalid = 1'b0;
    end
    // Bus: perform a write once address and data are both held
    if (state_reg.have_aw && state_reg.have_w) begin
      state_next.have_aw = 1'b0;
      state_next.have_w = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = addr_ok(state_reg.awaddr) ? sxp_pkg::RESP_OKAY
                                                   : sxp_pkg::RESP_SLVERR;
      wd = merge(rd_data(state_reg, state_reg.awaddr), state_reg.wdata,
                 state_reg.wstrb);
      for (int c = 0; c < sxp_pkg::NCH; c++) begin
        if (state_reg.awaddr == sxp_pkg::OFF_PRE0
            + sxp_pkg::REG_STRIDE * 32'(c)) begin
          state_next.prescale[c] = wd[7:0];
        end
        if (state_reg.awaddr == sxp_pkg::OFF_DUTY0
            + sxp_pkg::REG_STRIDE * 32'(c)) begin
          state_next.duty[c] = wd[7:0];
          if (c % 2 == 1) begin
            // High half written: pair value taken as one unit
            state_next.shadow[c / 2] = {wd[7:0], state_reg.duty[c - 1]};
          end
        end
      end
      if (state_reg.awaddr == sxp_pkg::OFF_MODE) begin
        state_next.mode_ctl = wd[sxp_pkg::MODE_BITS-1:0];
      end
      if (state_reg.awaddr == sxp_pkg::OFF_PHASE) begin
        state_next.phase_ctl = wd[sxp_pkg::NCH-1:0];
      end
      if (state_reg.awaddr == sxp_pkg::OFF_CLKSEL) begin
        state_next.clk_sel = wd[1:0];
      end
    end
    // Bus: take address and data in either order
    if (I_AXI.awvalid && state_reg.aw_rdy) begin
      state_next.have_aw = 1'b1;
      state_next.awaddr = I_AXI.awaddr;
    end
    if (I_AXI.wvalid && state_reg.w_rdy) begin
      state_next.have_w = 1'b1;
      state_next.wdata = I_AXI.wdata;
      state_next.wstrb = I_AXI.wstrb;
    end
    state_next.aw_rdy = !state_next.have_aw && !state_next.bvalid;
    state_next.w_rdy = !state_next.have_w && !state_next.bvalid;
    // Bus: read
    if (state_reg.rvalid && I_AXI.rready) begin
      state_next.rvalid = 1'b0;
    end
    if (I_AXI.arvalid && state_reg.ar_rdy) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_data(state_reg, I_AXI.araddr);
      state_next.rresp = addr_ok(I_AXI.araddr) ? sxp_pkg::RESP_OKAY
                                               : sxp_pkg::RESP_SLVERR;
    end
    state_next.ar_rdy = !state_next.rvalid;

    // Count clock: one tick every 1, 2, 4 or 8 system clocks
    mask = 3'((4'h1 << state_reg.clk_sel) - 4'h1);
    tick = (state_reg.div_cnt & mask) == mask;
    state_next.div_cnt = state_reg.div_cnt + 3'h1;

    // Channels
    for (int c = 0; c < sxp_pkg::NCH; c++) begin
      w = width_of(state_reg.mode_ctl, c / 2);
      idle = (c % 2 == 1) && (w == sxp_pkg::SXP_W12 || w == sxp_pkg::SXP_W16);
      dv = state_reg.mode_ctl[c] && !(w == sxp_pkg::SXP_W12 || w == sxp_pkg::SXP_W16);
      top = top_of(w, dv);
      if (!idle && tick) begin
        if (state_reg.cg_cnt[c] == 8'h00) begin
          pclk[c] = 1'b1;
          state_next.pre_lat[c] = state_reg.prescale[c];
          state_next.cg_cnt[c] = state_next.pre_lat[c];
        end else begin
          state_next.cg_cnt[c] = state_reg.cg_cnt[c] - 8'h01;
        end
      end
      if (pclk[c]) begin
        if (state_reg.duty_cnt[c] >= top) begin
          ovf[c] = 1'b1;
          state_next.duty_cnt[c] = 16'h0000;
          wide = state_reg.shadow[c / 2];
          if (w == sxp_pkg::SXP_W12) begin
            wide = {4'h0, wide[11:0]};
          end
          // Latch loads only here, never from the bus
          state_next.duty_lat[c] = (w == sxp_pkg::SXP_W12 || w == sxp_pkg::SXP_W16)
                                   ? wide : {8'h00, state_reg.duty[c]};
        end else begin
          state_next.duty_cnt[c] = state_reg.duty_cnt[c] + 16'h0001;
        end
      end
      if (idle) begin
        state_next.duty_cnt[c] = 16'h0000;
        state_next.cg_cnt[c] = 8'h00;
        raw[c] = 1'b0;
      end else if (dv) begin
        raw[c] = (state_reg.duty_cnt[c][3:0] < state_reg.duty_lat[c][7:4])
                 || (state_reg.duty_cnt[c][3:0] == sxp_pkg::SLOT_LAST
                     && add_pulse(state_reg.duty_lat[c][3:0],
                                  state_reg.duty_cnt[c][7:4]));
      end else begin
        raw[c] = state_reg.duty_cnt[c] < state_reg.duty_lat[c];
      end
      state_next.pins[c] = raw[c] ^ state_reg.phase_ctl[c];
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign O_PWM = state_reg.pins;
  assign O_AXI.awready = state_reg.aw_rdy;
  assign O_AXI.wready = state_reg.w_rdy;
  assign O_AXI.bvalid = state_reg.bvalid;
  assign O_AXI.bresp = state_reg.bresp;
  assign O_AXI.arready = state_reg.ar_rdy;
  assign O_AXI.rvalid = state_reg.rvalid;
  assign O_AXI.rdata = state_reg.rdata;
  assign O_AXI.rresp = state_reg.rresp;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  sequence s_fast_pclk;
    pclk[0] && state_reg.prescale[0] == 8'h02 && state_reg.clk_sel == 2'h0;
  endsequence

  sequence s_hi_write;
    state_reg.have_aw && state_reg.have_w && state_reg.wstrb[0]
      && state_reg.awaddr == sxp_pkg::OFF_DUTY0 + sxp_pkg::REG_STRIDE;
  endsequence

  a_duty_latch_load:
    assert property ($changed(state_reg.duty_lat[0]) |-> $past(ovf[0]))
      else $error("Duty latch changed without overflow");

  a_pre_latch_load:
    assert property ($changed(state_reg.pre_lat[0]) |-> $past(pclk[0]))
      else $error("Prescale latch changed without underflow");

  a_pclk_spacing:
    assert property ((s_fast_pclk ##1 (state_reg.clk_sel == 2'h0)[*3])
                     |-> !$past(pclk[0]) && !$past(pclk[0], 2)
                     && pclk[0])
      else $error("PWM clock spacing wrong for prescale 2");

  a_div8_gap:
    assert property ((tick && state_reg.clk_sel == 2'h3)
                     ##1 (state_reg.clk_sel == 2'h3) |-> !tick)
      else $error("Divide by 8 ticked on consecutive clocks");

  a_wrap_8bit:
    assert property (ovf[0] && !state_reg.mode_ctl[0]
                     && width_of(state_reg.mode_ctl, 0) == sxp_pkg::SXP_W8
                     |-> state_reg.duty_cnt[0] == sxp_pkg::CNT_TOP8)
      else $error("8-bit cycle not 255 steps");

  a_wrap_12bit:
    assert property (ovf[0] && width_of(state_reg.mode_ctl, 0) == sxp_pkg::SXP_W12
                     |-> state_reg.duty_cnt[0] == sxp_pkg::CNT_TOP12)
      else $error("12-bit cycle not 4095 steps");

  a_wrap_div:
    assert property (ovf[2] && state_reg.mode_ctl[2]
                     && width_of(state_reg.mode_ctl, 1) == sxp_pkg::SXP_W8
                     |-> state_reg.duty_cnt[2] == sxp_pkg::CNT_TOPDIV)
      else $error("Division period not 256 steps");

  a_odd_ignored:
    assert property (width_of(state_reg.mode_ctl, 2) == sxp_pkg::SXP_W16
                     ##1 width_of(state_reg.mode_ctl, 2) == sxp_pkg::SXP_W16
                     |-> !raw[5] && state_reg.duty_cnt[5] == 16'h0000)
      else $error("Odd channel counting in wide mode");

  a_full_duty:
    assert property (!state_reg.mode_ctl[0] && state_reg.duty_lat[0] == 16'h00FF
                     && width_of(state_reg.mode_ctl, 0) == sxp_pkg::SXP_W8 |-> raw[0])
      else $error("Full duty not high");

  a_wide_capture:
    assert property (s_hi_write |=> state_reg.shadow[0][15:8] == $past(state_reg.wdata[7:0])
                     && state_reg.shadow[0][7:0] == $past(state_reg.duty[0]))
      else $error("Wide duty not captured as one unit");

  a_pin_phase:
    assert property ($rose(state_reg.phase_ctl[3]) && $stable(raw[3]) |=> $changed(O_PWM[3]))
      else $error("Phase select did not invert the pin");

  a_bvalid_hold:
    assert property (state_reg.bvalid && !I_AXI.bready |=> state_reg.bvalid)
      else $error("Write response dropped before taken");

  a_rvalid_hold:
    assert property (state_reg.rvalid && !I_AXI.rready |=> state_reg.rvalid
                     && $stable(state_reg.rdata))
      else $error("Read data not held until taken");

  a_wrap_16bit:
    assert property (ovf[4] && width_of(state_reg.mode_ctl, 2) == sxp_pkg::SXP_W16
                     |-> state_reg.duty_cnt[4] == sxp_pkg::CNT_TOP16)
      else $error("16-bit cycle not 65535 steps");

  a_wide_latch:
    assert property (ovf[0] && width_of(state_reg.mode_ctl, 0) == sxp_pkg::SXP_W12
                     |=> state_reg.duty_lat[0] == {4'h0, $past(state_reg.shadow[0][11:0])})
      else $error("12-bit duty latch took high nibble bits");

  a_cg_reload:
    assert property (pclk[0] |=> state_reg.cg_cnt[0] == $past(state_reg.prescale[0]))
      else $error("Clock generator not reloaded from prescale");

  a_bad_addr_resp:
    assert property (state_reg.have_aw && state_reg.have_w && !addr_ok(state_reg.awaddr)
                     |=> state_reg.bvalid && state_reg.bresp == sxp_pkg::RESP_SLVERR)
      else $error("Unmapped write not answered with slave error");

endmodule
